// >>> hw/l2iqc_pkg.sv
/*
 * l2iqc_pkg: register map, vector layout and sizes of the layer-two
 * interrupt queue controller.
 * assumes: used by the controller and its bench, nothing else.
 */
package l2iqc_pkg;
    // ====
    // register offsets (byte addresses)
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_GSTAT   = 8'h04;
    localparam logic [7:0] A_GACK    = 8'h08;
    localparam logic [7:0] A_QMASK   = 8'h0C;
    localparam logic [7:0] A_HPMASK  = 8'h10;
    localparam logic [7:0] A_SYSQ    = 8'h14;
    localparam logic [7:0] A_DTHR    = 8'h18;
    localparam logic [7:0] A_DCNT    = 8'h1C;
    localparam logic [7:0] A_MBFIFO  = 8'h20;
    localparam logic [7:0] A_ISTAT   = 8'h24;
    localparam logic [7:0] A_ICLR    = 8'h28;
    localparam logic [7:0] A_IEN     = 8'h2C;
    localparam logic [7:0] A_QSTART  = 8'h40;
    localparam logic [7:0] A_QLEN    = 8'h80;
    // ====
    // control bits
    localparam int CTRL_FIFO_INTA = 0;
    localparam int CTRL_BRIDGE    = 1;
    // ====
    // vector layout
    localparam int V_ONE   = 31;
    localparam int V_GRP   = 29;
    localparam int V_SUB   = 27;
    localparam int V_QUE   = 24;
    localparam int SYS_RBF = 19;
    localparam logic [1:0] G_CMD  = 2'h0;
    localparam logic [1:0] G_CHAN = 2'h1;
    localparam logic [1:0] G_PORT = 2'h2;
    localparam logic [1:0] G_SYS  = 2'h3;
    // ====
    // queues
    localparam int NQ       = 9;
    localparam int NGQ      = 8;
    localparam logic [3:0] Q_HP  = 4'h7;
    localparam logic [3:0] Q_CMD = 4'h8;
    localparam logic [15:0] CMD_QLEN = 16'h0200;
    localparam logic [15:0] QLEN_RST = 16'h0001;
    // ====
    // local interrupt status bits
    localparam int I_VEC  = 0;
    localparam int I_DROP = 1;
    localparam int I_OVF  = 2;
    localparam int NI     = 3;
endpackage : l2iqc_pkg

// >>> hw/l2iqc_ctrl.sv
/*
 * l2iqc_ctrl: layer-two interrupt queue controller. takes event vectors,
 * writes them into ring queues in host memory, drives the pci interrupt,
 * buffers mailbox events for the local interrupt pin.
 * assumes: one 10 mhz clock, synchronous inputs, a memory writer that
 * answers each word with mem_ack_in, a register master per the plain port.
 */
// Our own choices: the placing of the registers and the address-and-strobe port.
// Operation
// R1: all command, channel, port, system events go through this controller to queues and inta
// R2: mailbox events sit in a fifo driving the local pin, optionally inta
// R3: local-bus interrupt may be bridged onto inta
// R4: after reset no vector is produced
// R5: each source gives vector plus target queue; vector goes there
// R6: channel events with hp mask bit set go to queue seven instead
// R7: writing a vector into an unmasked queue asserts inta
// R8: global status shows which queues hold new vectors
// R9: masked queue still gets vectors but does not assert inta
// R10: eight general ring queues with own start address and size
// R11: command queue has fixed size of two halves of 256 words
// R12: vectors are 32 bits with bit 31 written as one
// R13: layout: group 30:29, subclass 28:27, queue 26:24, payload 23:0
// R14: group codes: 00 command, 01 channel, 10 port, 11 system
// R15: subclass upper bit gives tx or rx path; payload passed as given
// R16: nine start addresses, eight lengths; queue 8 length fixed
// R17: drop count reaching threshold issues receive-fail system vector; count readable
// R18: per-queue write pointer wraps to start after last word
`timescale 1ns/10ps
module l2iqc_ctrl #(
    parameter int MB_DEPTH = 4,
    parameter int MB_WIDTH = 16
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        evt_valid_in,
    input  wire logic [1:0]  evt_group_in,
    input  wire logic [1:0]  evt_subclass_in,
    input  wire logic [2:0]  evt_queue_in,
    input  wire logic [23:0] evt_info_in,
    output logic             evt_ready_out,
    input  wire logic        rx_drop_in,
    input  wire logic        mbox_evt_in,
    input  wire logic [MB_WIDTH-1:0] mbox_info_in,
    input  wire logic        lbus_irq_n_in,
    output logic             mem_wr_out,
    output logic      [31:0] mem_addr_out,
    output logic      [31:0] mem_wdata_out,
    input  wire logic        mem_ack_in,
    output logic             pci_inta_n_out,
    output logic             local_irq_pin_n_out,
    output logic             irq_out
);
    // ====
    // parameter checks
    initial
    begin
        if (MB_DEPTH < 2 || MB_DEPTH > 256 || MB_WIDTH < 1 || MB_WIDTH > 31)
            $error("l2iqc_ctrl: unsupported mailbox fifo shape");
    end

    localparam int MBA = $clog2(MB_DEPTH);

    // ====
    // helpers
    function automatic logic [31:0] build_vec(input logic [1:0]  grp,
                                              input logic [1:0]  sub,
                                              input logic [2:0]  que,
                                              input logic [23:0] info);
        logic [31:0] v;
        v = {8'h00, info};
        v[l2iqc_pkg::V_ONE] = 1'b1;                         // [R12]
        v[l2iqc_pkg::V_GRP +: 2] = grp;                     // [R13] [R14]
        v[l2iqc_pkg::V_SUB +: 2] = sub;                     // [R15]
        v[l2iqc_pkg::V_QUE +: 3] = que;                     // [R13]
        return v;
    endfunction : build_vec

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] o);
        return reg_wr_in && (reg_addr_in == a + o);
    endfunction : wr_hit

    typedef enum logic [0:0] {S_IDLE, S_WRITE} l2iqc_state_t;

    // ====
    // registers
    l2iqc_state_t            state_q;
    logic                    ready_q;
    logic [1:0]              ctrl_q;
    logic [l2iqc_pkg::NQ-1:0] gstat_q;
    logic [l2iqc_pkg::NQ-1:0] qmask_q;
    logic [l2iqc_pkg::NGQ-1:0] hpmask_q;
    logic [2:0]              sysq_q;
    logic [15:0]             dthr_q;
    logic [15:0]             dcnt_q;
    logic                    sys_pend_q;
    logic [31:0]             qstart_q [l2iqc_pkg::NQ];
    logic [15:0]             qlen_q   [l2iqc_pkg::NGQ];
    logic [15:0]             ptr_q    [l2iqc_pkg::NQ];
    logic [3:0]              cur_q;
    logic [l2iqc_pkg::NI-1:0] istat_q;
    logic [l2iqc_pkg::NI-1:0] ien_q;
    logic [MB_WIDTH-1:0]     mb_mem_q [MB_DEPTH];
    logic [MBA:0]            mb_cnt_q;
    logic [MBA-1:0]          mb_rd_q;
    logic [MBA-1:0]          mb_wr_q;

    // ==========================================================
    // event intake and queue selection
    logic [3:0]  sel_q_d;
    logic        done;
    logic        mb_pop;
    logic        mb_push;
    logic        drop_hit;

    always_comb
    begin
        sel_q_d = {1'b0, evt_queue_in};                     // [R5]
        if (evt_group_in == l2iqc_pkg::G_CMD)
            sel_q_d = l2iqc_pkg::Q_CMD;                     // [R11]
        else if (evt_group_in == l2iqc_pkg::G_CHAN && hpmask_q[evt_queue_in])
            sel_q_d = l2iqc_pkg::Q_HP;                      // [R6]
    end

    assign done     = (state_q == S_WRITE) && mem_ack_in;
    assign mb_pop   = reg_rd_in && reg_addr_in == l2iqc_pkg::A_MBFIFO && mb_cnt_q != '0;
    assign mb_push  = mbox_evt_in && (mb_cnt_q != MB_DEPTH[MBA:0] || mb_pop);
    assign drop_hit = rx_drop_in && dthr_q != 16'h0000 && dcnt_q + 16'h0001 == dthr_q;

    // ==========================================================
    // write engine: one vector at a time, system vector behind events
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q       <= S_IDLE;                        // [R4]
            ready_q       <= 1'b0;
            cur_q         <= 4'h0;
            mem_wr_out    <= 1'b0;
            mem_addr_out  <= 32'h0000_0000;
            mem_wdata_out <= 32'h0000_0000;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (ready_q && evt_valid_in)
                    begin
                        ready_q       <= 1'b0;
                        cur_q         <= sel_q_d;           // [R1]
                        mem_wdata_out <= build_vec(evt_group_in, evt_subclass_in,
                                                   sel_q_d[2:0], evt_info_in);
                        mem_addr_out  <= qstart_q[sel_q_d] + {14'h0000, ptr_q[sel_q_d], 2'h0};
                        mem_wr_out    <= 1'b1;
                        state_q       <= S_WRITE;
                    end
                    else if (sys_pend_q)
                    begin
                        ready_q       <= 1'b0;
                        cur_q         <= {1'b0, sysq_q};
                        mem_wdata_out <= build_vec(l2iqc_pkg::G_SYS, 2'h0, sysq_q,
                                                   24'h1 << l2iqc_pkg::SYS_RBF); // [R17]
                        mem_addr_out  <= qstart_q[sysq_q] + {14'h0000, ptr_q[sysq_q], 2'h0};
                        mem_wr_out    <= 1'b1;
                        state_q       <= S_WRITE;
                    end
                    else
                        ready_q <= 1'b1;
                end
                S_WRITE:
                begin
                    if (mem_ack_in)
                    begin
                        mem_wr_out <= 1'b0;
                        state_q    <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    assign evt_ready_out = ready_q;

    // ==========================================================
    // write pointers, wrap at configured length (queue 8 at fixed CMD_QLEN of 512 words)
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < l2iqc_pkg::NQ; i++)
                ptr_q[i] <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < l2iqc_pkg::NQ; i++)
            begin
                if (wr_hit(l2iqc_pkg::A_QSTART, 8'(4 * i)))
                    ptr_q[i] <= 16'h0000;
                else if (done && cur_q == 4'(i))
                begin
                    logic [15:0] len;
                    len = (i == l2iqc_pkg::NQ - 1) ? l2iqc_pkg::CMD_QLEN  // [R11]
                        : qlen_q[i < l2iqc_pkg::NGQ ? i : 0];          // [R10]
                    if (len == 16'h0000 || ptr_q[i] + 16'h0001 >= len)
                        ptr_q[i] <= 16'h0000;                         // [R18]
                    else
                        ptr_q[i] <= ptr_q[i] + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_q   <= 2'h0;
            qmask_q  <= '0;
            hpmask_q <= '0;
            sysq_q   <= 3'h0;
            dthr_q   <= 16'h0000;
            ien_q    <= '0;
            for (int i = 0; i < l2iqc_pkg::NQ; i++)
                qstart_q[i] <= 32'h0000_0000;
            for (int i = 0; i < l2iqc_pkg::NGQ; i++)
                qlen_q[i] <= l2iqc_pkg::QLEN_RST;
        end
        else
        begin
            if (wr_hit(l2iqc_pkg::A_CTRL, 8'h00))
                ctrl_q <= reg_wdata_in[1:0];
            if (wr_hit(l2iqc_pkg::A_QMASK, 8'h00))
                qmask_q <= reg_wdata_in[l2iqc_pkg::NQ-1:0];   // [R9]
            if (wr_hit(l2iqc_pkg::A_HPMASK, 8'h00))
                hpmask_q <= reg_wdata_in[l2iqc_pkg::NGQ-1:0]; // [R6]
            if (wr_hit(l2iqc_pkg::A_SYSQ, 8'h00))
                sysq_q <= reg_wdata_in[2:0];
            if (wr_hit(l2iqc_pkg::A_DTHR, 8'h00))
                dthr_q <= reg_wdata_in[15:0];
            if (wr_hit(l2iqc_pkg::A_IEN, 8'h00))
                ien_q <= reg_wdata_in[l2iqc_pkg::NI-1:0];
            for (int i = 0; i < l2iqc_pkg::NQ; i++)
                if (wr_hit(l2iqc_pkg::A_QSTART, 8'(4 * i)))
                    qstart_q[i] <= {reg_wdata_in[31:2], 2'h0}; // [R16]
            for (int i = 0; i < l2iqc_pkg::NGQ; i++)
                if (wr_hit(l2iqc_pkg::A_QLEN, 8'(4 * i)))
                    qlen_q[i] <= reg_wdata_in[15:0];           // [R16]
        end
    end

    // ==========================================================
    // global status: set on vector written, write-one ack; set wins
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            gstat_q <= '0;
        else
        begin
            for (int i = 0; i < l2iqc_pkg::NQ; i++)
            begin
                if (done && cur_q == 4'(i))
                    gstat_q[i] <= 1'b1;                      // [R8]
                else if (wr_hit(l2iqc_pkg::A_GACK, 8'h00) && reg_wdata_in[i])
                    gstat_q[i] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // receive drop counter and threshold
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dcnt_q     <= 16'h0000;
            sys_pend_q <= 1'b0;
        end
        else
        begin
            if (rx_drop_in && dcnt_q != 16'hFFFF)
                dcnt_q <= dcnt_q + 16'h0001;                 // [R17]
            else if (wr_hit(l2iqc_pkg::A_DCNT, 8'h00))
                dcnt_q <= 16'h0000;
            if (drop_hit)
                sys_pend_q <= 1'b1;                          // [R17]
            else if (state_q == S_IDLE && !(ready_q && evt_valid_in))
                sys_pend_q <= 1'b0;
        end
    end

    // ==========================================================
    // mailbox fifo; a read of its register pops one entry
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mb_cnt_q <= '0;
            mb_rd_q  <= '0;
            mb_wr_q  <= '0;
            for (int i = 0; i < MB_DEPTH; i++)
                mb_mem_q[i] <= '0;
        end
        else
        begin
            if (mb_push)
            begin
                mb_mem_q[mb_wr_q] <= mbox_info_in;             // [R2]
                mb_wr_q <= (mb_wr_q == MBA'(MB_DEPTH - 1)) ? '0 : mb_wr_q + 1'b1;
            end
            if (mb_pop)
                mb_rd_q <= (mb_rd_q == MBA'(MB_DEPTH - 1)) ? '0 : mb_rd_q + 1'b1;
            if (mb_push && !mb_pop)
                mb_cnt_q <= mb_cnt_q + 1'b1;
            else if (mb_pop && !mb_push)
                mb_cnt_q <= mb_cnt_q - 1'b1;
        end
    end

    // ==========================================================
    // pins: inta low on unmasked queue status, fifo or bridge
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pci_inta_n_out      <= 1'b1;
            local_irq_pin_n_out <= 1'b1;
        end
        else
        begin
            pci_inta_n_out <= !(|(gstat_q & ~qmask_q)                      // [R7] [R9]
                || (ctrl_q[l2iqc_pkg::CTRL_FIFO_INTA] && mb_cnt_q != '0)  // [R2]
                || (ctrl_q[l2iqc_pkg::CTRL_BRIDGE] && !lbus_irq_n_in));   // [R3]
            local_irq_pin_n_out <= (mb_cnt_q == '0);                       // [R2]
        end
    end

    // ==========================================================
    // local interrupt status, clear register, enable
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            istat_q <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            logic [l2iqc_pkg::NI-1:0] set;
            set = '0;
            set[l2iqc_pkg::I_VEC]  = done;
            set[l2iqc_pkg::I_DROP] = drop_hit;
            set[l2iqc_pkg::I_OVF]  = mbox_evt_in && !mb_push;
            if (wr_hit(l2iqc_pkg::A_ICLR, 8'h00))
                istat_q <= (istat_q & ~reg_wdata_in[l2iqc_pkg::NI-1:0]) | set;
            else
                istat_q <= istat_q | set;
            irq_out <= |(istat_q & ien_q);
        end
    end

    // ==========================================================
    // read port; unmapped and write-only addresses read zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_rd_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
            case (reg_addr_in)
                l2iqc_pkg::A_CTRL:   reg_rdata_out <= {30'h0, ctrl_q};
                l2iqc_pkg::A_GSTAT:  reg_rdata_out <= {23'h0, gstat_q};   // [R8]
                l2iqc_pkg::A_QMASK:  reg_rdata_out <= {23'h0, qmask_q};
                l2iqc_pkg::A_HPMASK: reg_rdata_out <= {24'h0, hpmask_q};
                l2iqc_pkg::A_SYSQ:   reg_rdata_out <= {29'h0, sysq_q};
                l2iqc_pkg::A_DTHR:   reg_rdata_out <= {16'h0, dthr_q};
                l2iqc_pkg::A_DCNT:   reg_rdata_out <= {16'h0, dcnt_q};    // [R17]
                l2iqc_pkg::A_ISTAT:  reg_rdata_out <= {29'h0, istat_q};
                l2iqc_pkg::A_IEN:    reg_rdata_out <= {29'h0, ien_q};
                l2iqc_pkg::A_MBFIFO:
                    if (mb_cnt_q != '0)
                        reg_rdata_out <= {1'b1, (31 - MB_WIDTH)'(0), mb_mem_q[mb_rd_q]};
                default:
                begin
                    for (int i = 0; i < l2iqc_pkg::NQ; i++)
                        if (reg_addr_in == l2iqc_pkg::A_QSTART + 8'(4 * i))
                            reg_rdata_out <= qstart_q[i];
                    for (int i = 0; i < l2iqc_pkg::NGQ; i++)
                        if (reg_addr_in == l2iqc_pkg::A_QLEN + 8'(4 * i))
                            reg_rdata_out <= {16'h0, qlen_q[i]};
                end
            endcase
        end
    end
endmodule : l2iqc_ctrl

// >>> verif/l2iqc_chk.sv
/*
 * l2iqc_chk: port assertions of the interrupt queue controller.
 * assumes: bound into l2iqc_ctrl, one clock, async active-low reset.
 */
`timescale 1ns/10ps
module l2iqc_chk (
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        evt_valid_in,
    input wire logic [1:0]  evt_group_in,
    input wire logic [1:0]  evt_subclass_in,
    input wire logic [23:0] evt_info_in,
    input wire logic        evt_ready_out,
    input wire logic        mbox_evt_in,
    input wire logic        mem_wr_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [31:0] mem_wdata_out,
    input wire logic        mem_ack_in,
    input wire logic        local_irq_pin_n_out
);
    // ====
    // word launch and hold
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    wire take = evt_valid_in && evt_ready_out;
    one_bit_a: assert property (mem_wr_out |-> mem_wdata_out[31])
        else $error("vector bit 31 not set");
    hold_word_a: assert property (mem_wr_out && !mem_ack_in |=> mem_wr_out
        && $stable(mem_addr_out) && $stable(mem_wdata_out))
        else $error("memory word changed before ack");
    take_launch_a: assert property (take |=> mem_wr_out && !evt_ready_out)
        else $error("taken event not launched");
    vec_layout_a: assert property (take |=> mem_wdata_out[23:0] == $past(evt_info_in)
        && mem_wdata_out[30:27] == {$past(evt_group_in), $past(evt_subclass_in)})
        else $error("vector fields wrong");
    ack_end_a: assert property (mem_wr_out && mem_ack_in |=> !mem_wr_out)
        else $error("write held after ack");
    quiet_start_a: assert property ($rose(rst_n_in) |-> !mem_wr_out [*2])
        else $error("vector right after reset");
    word_align_a: assert property (mem_wr_out |-> mem_addr_out[1:0] == 2'h0)
        else $error("queue address unaligned");
    mbox_pin_a: assert property (mbox_evt_in |-> ##2 !local_irq_pin_n_out)
        else $error("local pin not low after push");
endmodule : l2iqc_chk

bind l2iqc_ctrl l2iqc_chk chk_i (.*);

// >>> verif/l2iqc_mem_model.sv
/*
 * l2iqc_mem_model: host memory taking queue words one at a time.
 * assumes: lat_in idle cycles before each ack; keeps the last word seen.
 */
`timescale 1ns/10ps
module l2iqc_mem_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        mem_wr_out,
    input  wire logic [31:0] mem_addr_out,
    input  wire logic [31:0] mem_wdata_out,
    output logic             mem_ack_in,
    input  wire logic [3:0]  lat_in,
    output logic [7:0]       n_out,
    output logic [31:0]      addr_out,
    output logic [31:0]      data_out
);
    // ====
    // slow or prompt acceptance; no bit 31 clearing modelled
    logic [3:0] wait_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_ack_in <= 1'b0;
            wait_q     <= 4'h0;
            n_out      <= 8'h00;
            addr_out   <= 32'h0;
            data_out   <= 32'h0;
        end
        else if (mem_ack_in)
        begin
            mem_ack_in <= 1'b0; // word stored as written
            n_out      <= n_out + 8'h01;
            addr_out   <= mem_addr_out;
            data_out   <= mem_wdata_out;
        end
        else if (mem_wr_out)
        begin
            mem_ack_in <= (wait_q >= lat_in);
            wait_q     <= (wait_q >= lat_in) ? 4'h0 : wait_q + 4'h1;
        end
    end
endmodule : l2iqc_mem_model

// >>> verif/l2iqc_ctrl_bench.sv
/*
 * l2iqc_ctrl_bench: register and event tests of the queue controller.
 * assumes: memory model at the far side, 10 mhz clock.
 */
`timescale 1ns/10ps
module l2iqc_ctrl_bench;
    // ====
    // signals
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic evt_valid_in = 1'b0, rx_drop_in = 1'b0, mbox_evt_in = 1'b0, lbus_irq_n_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [1:0] evt_group_in = 2'h0, evt_subclass_in = 2'h0;
    logic [2:0] evt_queue_in = 3'h0, gv;
    logic [23:0] evt_info_in = 24'h0;
    logic [15:0] mbox_info_in = 16'h0;
    logic [31:0] reg_rdata_out, mem_addr_out, mem_wdata_out, addr_out, data_out;
    logic mem_wr_out, mem_ack_in, pci_inta_n_out, local_irq_pin_n_out, irq_out;
    logic evt_ready_out;
    logic [3:0] lat_in = 4'h0;
    logic [7:0] n_out, seen = 8'h00;
    int bad_count = 0, checks_done = 0, cyc = 0, i;
    l2iqc_ctrl dut (.*);
    l2iqc_mem_model mm (.*);
    initial
    begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // ====
    // tasks
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
        #1 chk(nm, reg_rdata_out, e);
    endtask : rdc
    task automatic ev(input logic [1:0] g, s, input logic [2:0] q, input logic [23:0] f);
        @(posedge clk_sys_in);
        evt_valid_in    <= 1'b1;
        evt_group_in    <= g;
        evt_subclass_in <= s;
        evt_queue_in    <= q;
        evt_info_in     <= f;
        @(negedge clk_sys_in);
        for (int k = 0; k < 40 && evt_ready_out !== 1'b1; k++) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
        evt_valid_in <= 1'b0;
    endtask : ev
    task automatic mem_exp(input logic [31:0] a, input logic [31:0] d);
        for (int k = 0; k < 60 && n_out === seen; k++) @(negedge clk_sys_in);
        seen = seen + 8'h01;
        chk("mem addr", addr_out, a);
        chk("mem data", data_out, d);
    endtask : mem_exp
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // ====
    // hang guard: whole run is a few hundred cycles
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            bad_count++;
            summarize();
        end
    end
    // ====
    // tests
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rdc("qlen0", l2iqc_pkg::A_QLEN, 32'h1);
        rdc("unmapped", 8'h3C, 32'h0);
        rdc("gstat", l2iqc_pkg::A_GSTAT, 32'h0);
        chk("inta", {31'h0, pci_inta_n_out}, 32'h1);
        $display("test reset done");
        wr(8'h40, 32'h1000);
        wr(8'h80, 32'h2);
        for (i = 0; i < 3; i++)
        begin
            lat_in <= i[3:0];
            ev(2'h1, 2'h2, 3'h0, 24'h00ABCD);
            mem_exp(32'h1000 | (i[0] ? 32'h4 : 32'h0), 32'hB000ABCD);
        end
        rdc("gstat", l2iqc_pkg::A_GSTAT, 32'h1);
        chk("inta", {31'h0, pci_inta_n_out}, 32'h0);
        $display("test ring done");
        wr(8'h44, 32'h2000);
        wr(8'h84, 32'h8);
        wr(8'h60, 32'h8000);
        for (gv = 3'h0; gv < 3'h4; gv++)
        begin
            ev(gv[1:0], gv[1:0], 3'h1, 24'h0000F0);
            mem_exp(gv == 3'h0 ? 32'h8000 : 32'h2000 + {27'h0, gv - 3'h1, 2'h0},
                {1'b1, gv[1:0], gv[1:0], gv == 3'h0 ? 3'h0 : 3'h1, 24'h0000F0});
        end
        $display("test groups done");
        wr(l2iqc_pkg::A_HPMASK, 32'h4);
        wr(8'h5C, 32'h7000);
        ev(2'h1, 2'h0, 3'h2, 24'h000077);
        mem_exp(32'h7000, 32'hA7000077);
        ev(2'h2, 2'h0, 3'h2, 24'h000022);
        mem_exp(32'h0, 32'hC2000022);
        $display("test priority done");
        wr(l2iqc_pkg::A_GACK, 32'h1FF);
        wr(l2iqc_pkg::A_QMASK, 32'h8);
        rdc("gstat", l2iqc_pkg::A_GSTAT, 32'h0);
        ev(2'h2, 2'h1, 3'h3, 24'h000033);
        mem_exp(32'h0, 32'hCB000033);
        rdc("gstat", l2iqc_pkg::A_GSTAT, 32'h8);
        chk("inta", {31'h0, pci_inta_n_out}, 32'h1);
        $display("test mask done");
        rdc("istat", l2iqc_pkg::A_ISTAT, 32'h1);
        chk("irq off", {31'h0, irq_out}, 32'h0);
        wr(l2iqc_pkg::A_IEN, 32'h1);
        repeat (2) @(negedge clk_sys_in);
        chk("irq on", {31'h0, irq_out}, 32'h1);
        wr(l2iqc_pkg::A_ICLR, 32'h1);
        repeat (2) @(negedge clk_sys_in);
        chk("irq clr", {31'h0, irq_out}, 32'h0);
        $display("test irq done");
        wr(l2iqc_pkg::A_SYSQ, 32'h5);
        wr(8'h54, 32'h5000);
        wr(l2iqc_pkg::A_DTHR, 32'h2);
        repeat (2)
        begin
            @(posedge clk_sys_in);
            rx_drop_in <= 1'b1;
            @(posedge clk_sys_in);
            rx_drop_in <= 1'b0;
        end
        mem_exp(32'h5000, 32'hE5080000);
        rdc("dcnt", l2iqc_pkg::A_DCNT, 32'h2);
        rdc("istat", l2iqc_pkg::A_ISTAT, 32'h3);
        $display("test drop done");
        wr(l2iqc_pkg::A_GACK, 32'h1FF);
        wr(l2iqc_pkg::A_QMASK, 32'h1FF);
        wr(l2iqc_pkg::A_CTRL, 32'h1);
        @(posedge clk_sys_in);
        mbox_evt_in  <= 1'b1;
        mbox_info_in <= 16'h1234;
        @(posedge clk_sys_in);
        mbox_evt_in  <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk("local pin", {31'h0, local_irq_pin_n_out}, 32'h0);
        chk("fifo inta", {31'h0, pci_inta_n_out}, 32'h0);
        rdc("mbfifo", l2iqc_pkg::A_MBFIFO, 32'h80001234);
        repeat (2) @(negedge clk_sys_in);
        chk("local pin", {31'h0, local_irq_pin_n_out}, 32'h1);
        $display("test mailbox done");
        wr(l2iqc_pkg::A_CTRL, 32'h2);
        @(posedge clk_sys_in);
        lbus_irq_n_in <= 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk("bridge", {31'h0, pci_inta_n_out}, 32'h0);
        @(posedge clk_sys_in);
        lbus_irq_n_in <= 1'b1;
        repeat (3) @(negedge clk_sys_in);
        chk("bridge off", {31'h0, pci_inta_n_out}, 32'h1);
        $display("test bridge done");
        summarize();
    end
endmodule : l2iqc_ctrl_bench
